// ==== converter_status_model.sv ====
// Converter stand-in that drives the two analog status lines of the bank.
// Assumes the bank synchronises both lines; they move off the clock edge.
`timescale 1ns/1ps
module converter_status_model (
    input  wire logic clk,
    input  wire logic busy_cmd,
    input  wire logic floor_cmd,
    output logic      transition_in_progress = 1'b0,
    output logic      floor_reached = 1'b0
);
    // Lines settle 37 ns after the edge, so they never coincide with sampling
    always @(posedge clk) begin
        transition_in_progress <= #37 busy_cmd;
        floor_reached          <= #37 floor_cmd;
    end
endmodule // converter_status_model

// ==== regulator_control_regs.sv ====
// Control and status bank of the I/O rail and the core rail converters.
// Assumes the control-interface engine presents one access per strobe on
// the same clock; converter status lines arrive from analog, unsynchronised.
`timescale 1ns/1ps

module regulator_control_regs
    import regulator_ctrl_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire reg_req_type   reg_req,
    output logic [7:0]         reg_rdata,
    input  wire logic          warm_reset,
    input  wire power_req_type power_req,
    input  wire logic [3:0]    core_resource_state,
    input  wire logic          vscale_enable,
    input  wire logic [6:0]    vscale_level,
    input  wire logic          transition_in_progress,
    input  wire logic          floor_reached,
    output rail_ctrl_type      rail_ctrl
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Only writable bits move; read-only neighbours keep their value
    function automatic logic [7:0] masked_write(input logic [7:0] old_value,
                                                input logic [7:0] new_value,
                                                input logic [7:0] mask);
        masked_write = (old_value & ~mask) | (new_value & mask);
    endfunction

    // Write strike on one register address
    function automatic logic hit(input reg_req_type req, input logic [7:0] addr);
        hit = req.write && (req.addr == addr);
    endfunction

    bank_state_type state_reg;
    bank_state_type state_next;
    logic [6:0]     ctrl_level;
    logic [7:0]     read_value;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Level that really steers the core converter from the next cycle on
    assign ctrl_level = vscale_enable ? vscale_level
                                      : state_reg.core_level[6:0];

    // Register updates, warm reset, status capture and read data capture
    always_comb begin
        state_next = state_reg;

        // Plain stored fields, including the spare osc bit 6 and ramp bits
        if (hit(reg_req, ADDR_IO_CFG)) begin
            state_next.io_cfg = masked_write(state_reg.io_cfg, reg_req.wdata,
                                             MASK_CFG);
        end
        if (hit(reg_req, ADDR_IO_MISC)) begin
            state_next.io_misc = masked_write(state_reg.io_misc, reg_req.wdata,
                                              MASK_MISC);
        end
        if (hit(reg_req, ADDR_IO_OSC)) begin
            state_next.io_osc = masked_write(state_reg.io_osc, reg_req.wdata,
                                             MASK_OSC);
        end
        if (hit(reg_req, ADDR_IO_LEVEL)) begin
            state_next.io_level = masked_write(state_reg.io_level, reg_req.wdata,
                                               MASK_IOLVL);
        end
        if (hit(reg_req, ADDR_CORE_GRP)) begin
            state_next.core_grp = masked_write(state_reg.core_grp, reg_req.wdata,
                                               MASK_GRP);
        end
        if (hit(reg_req, ADDR_CORE_KIND)) begin
            state_next.core_kind = masked_write(state_reg.core_kind, reg_req.wdata,
                                                MASK_KIND);
        end
        if (hit(reg_req, ADDR_CORE_REMAP)) begin
            state_next.core_remap = masked_write(state_reg.core_remap, reg_req.wdata,
                                                 MASK_REMAP);
        end
        if (hit(reg_req, ADDR_CORE_CFG)) begin
            state_next.core_cfg = masked_write(state_reg.core_cfg, reg_req.wdata,
                                               MASK_CFG);
        end
        if (hit(reg_req, ADDR_CORE_MISC)) begin
            state_next.core_misc = masked_write(state_reg.core_misc, reg_req.wdata,
                                                MASK_MISC);
        end
        if (hit(reg_req, ADDR_CORE_OSC)) begin
            state_next.core_osc = masked_write(state_reg.core_osc, reg_req.wdata,
                                               MASK_OSC);
        end
        if (hit(reg_req, ADDR_CORE_LEVEL)) begin
            state_next.core_level = masked_write(state_reg.core_level, reg_req.wdata,
                                                 MASK_LEVEL);
        end
        if (hit(reg_req, ADDR_CORE_MODE)) begin
            state_next.core_mode = masked_write(state_reg.core_mode, reg_req.wdata,
                                                MASK_MODE);
        end
        if (hit(reg_req, ADDR_CORE_FLOOR)) begin
            state_next.core_floor = masked_write(state_reg.core_floor, reg_req.wdata,
                                                 MASK_LEVEL);
        end

        // Warm reset overrides a write in the same cycle
        // Policy bit is read from the old value, so a same-cycle write cannot arm it
        if (warm_reset) begin
            state_next.io_level   = RST_ZERO;
            state_next.core_level = RST_LEVEL;
            if (state_reg.core_grp[WARM_BIT]) begin
                state_next.core_grp[GRP_LSB +: 3] = GRP_ALL;
            end
        end

        // Three-stage capture; a change counts once stages two and three agree
        // Stage one feeds only stage two, so a metastable sample never decides
        state_next.busy_sync    = {state_reg.busy_sync[1:0], transition_in_progress};
        state_next.reached_sync = {state_reg.reached_sync[1:0], floor_reached};
        if (state_reg.busy_sync[1] == state_reg.busy_sync[2]) begin
            state_next.busy = state_reg.busy_sync[2];
        end
        if (state_reg.reached_sync[1] == state_reg.reached_sync[2]) begin
            state_next.reached = state_reg.reached_sync[2];
        end

        // Levels handed to the converter
        state_next.active_level = ctrl_level;
        state_next.sleep_level  = state_reg.core_mode[FLOOR_BIT]
                                ? state_reg.core_floor[6:0]
                                : ctrl_level;

        // Resource state for the system request, remapped for off and sleep
        unique case (power_req)
            REQ_OFF:   state_next.target_state = state_reg.core_remap[OFF_LSB +: 4];
            REQ_SLEEP: state_next.target_state = state_reg.core_remap[3:0];
            REQ_ACTIVE: state_next.target_state = STATE_ACTIVE;
            default:   state_next.target_state = STATE_ACTIVE;
        endcase

        if (reg_req.read) begin
            state_next.rdata = read_value;
        end
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************

    // Live fields are merged here so stored copies never hold them
    always_comb begin
        unique case (reg_req.addr)
            ADDR_IO_CFG:     read_value = state_reg.io_cfg;
            ADDR_IO_MISC:    read_value = state_reg.io_misc;
            ADDR_IO_OSC:     read_value = state_reg.io_osc;
            ADDR_IO_LEVEL:   read_value = state_reg.io_level;
            ADDR_CORE_GRP:   read_value = {state_reg.core_grp[7:4],
                                           core_resource_state};
            ADDR_CORE_KIND:  read_value = state_reg.core_kind;
            ADDR_CORE_REMAP: read_value = state_reg.core_remap;
            ADDR_CORE_CFG:   read_value = state_reg.core_cfg;
            ADDR_CORE_MISC:  read_value = state_reg.core_misc;
            ADDR_CORE_OSC:   read_value = state_reg.core_osc;
            ADDR_CORE_LEVEL: read_value = state_reg.core_mode[READBACK_BIT]
                                        ? state_reg.core_level
                                        : {1'b0, ctrl_level};
            ADDR_CORE_MODE:  read_value = state_reg.core_mode
                                        | ({7'h00, state_reg.busy} << BUSY_BIT)
                                        | ({7'h00, state_reg.reached} << REACHED_BIT);
            ADDR_CORE_FLOOR: read_value = state_reg.core_floor;
            default:         read_value = RST_ZERO;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset values come straight from the package constants
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg              <= '0;
            state_reg.core_grp     <= RST_GRP;
            state_reg.core_kind    <= RST_KIND;
            state_reg.core_remap   <= RST_REMAP;
            state_reg.core_level   <= RST_LEVEL;
            state_reg.active_level <= RST_LEVEL[6:0];
            state_reg.sleep_level  <= RST_LEVEL[6:0];
            state_reg.target_state <= STATE_ACTIVE;
            state_reg.busy_sync    <= SYNC_CLEAR;
            state_reg.reached_sync <= SYNC_CLEAR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Every output is a flip-flop slice
    assign reg_rdata                   = state_reg.rdata;
    assign rail_ctrl.io_cfg            = state_reg.io_cfg[1:0];
    assign rail_ctrl.io_misc           = state_reg.io_misc[4:0];
    assign rail_ctrl.io_osc            = state_reg.io_osc[4:0];
    assign rail_ctrl.io_level_high     = state_reg.io_level[0];
    assign rail_ctrl.core_group        = state_reg.core_grp[GRP_LSB +: 3];
    assign rail_ctrl.core_kind         = state_reg.core_kind[4:0];
    assign rail_ctrl.core_cfg          = state_reg.core_cfg[1:0];
    assign rail_ctrl.core_misc         = state_reg.core_misc[4:0];
    assign rail_ctrl.core_osc          = state_reg.core_osc[4:0];
    assign rail_ctrl.core_active_level = state_reg.active_level;
    assign rail_ctrl.core_sleep_level  = state_reg.sleep_level;
    assign rail_ctrl.core_target_state = state_reg.target_state;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    level_write_a: assert property (
        hit(reg_req, ADDR_CORE_LEVEL) && !warm_reset && !vscale_enable
        |=> ##1 rail_ctrl.core_active_level == $past(reg_req.wdata[6:0], 2))
        else $error("core level write did not reach converter");

    warm_group_a: assert property (
        warm_reset && state_reg.core_grp[WARM_BIT]
        |=> rail_ctrl.core_group == GRP_ALL && state_reg.core_level == RST_LEVEL)
        else $error("warm reset did not force group and level");

    warm_keep_a: assert property (
        warm_reset && !state_reg.core_grp[WARM_BIT] && !reg_req.write
        |=> $stable(rail_ctrl.core_group) && !rail_ctrl.io_level_high)
        else $error("warm reset changed group without policy");

    readback_sel_a: assert property (
        reg_req.read && reg_req.addr == ADDR_CORE_LEVEL
        |=> reg_rdata == ($past(state_reg.core_mode[READBACK_BIT])
                          ? $past(state_reg.core_level) : {1'b0, $past(ctrl_level)}))
        else $error("core level readback source wrong");

    state_field_a: assert property (
        reg_req.read && reg_req.addr == ADDR_CORE_GRP
        |=> reg_rdata[3:0] == $past(core_resource_state))
        else $error("group register state field wrong");

    busy_sync_a: assert property (
        transition_in_progress [*4] |=> state_reg.busy)
        else $error("busy status missed a steady transition");

    reached_sync_a: assert property (
        !floor_reached [*4] |=> !state_reg.reached)
        else $error("floor status set while not reached");

    sleep_floor_a: assert property (
        state_reg.core_mode[FLOOR_BIT]
        |=> rail_ctrl.core_sleep_level == $past(state_reg.core_floor[6:0]))
        else $error("sleep level ignored floor selection");

    off_remap_a: assert property (
        power_req == REQ_OFF
        |=> rail_ctrl.core_target_state == $past(state_reg.core_remap[7:4]))
        else $error("off request not remapped");

    reserved_zero_a: assert property (
        reg_req.read && reg_req.addr == ADDR_IO_LEVEL |=> reg_rdata[7:1] == 7'h00)
        else $error("reserved level bits read nonzero");

    // Per-field write paths, sleep remap and status read; warm reset is excluded where it would override
    group_write_a: assert property (
        hit(reg_req, ADDR_CORE_GRP) && !warm_reset
        |=> rail_ctrl.core_group == $past(reg_req.wdata[GRP_LSB +: 3]))
        else $error("group write did not reach the group field");

    kind_write_a: assert property (
        hit(reg_req, ADDR_CORE_KIND)
        |=> rail_ctrl.core_kind == $past(reg_req.wdata[4:0]))
        else $error("kind write did not reach the kind fields");

    core_cfg_a: assert property (
        hit(reg_req, ADDR_CORE_CFG)
        |=> rail_ctrl.core_cfg == $past(reg_req.wdata[1:0]))
        else $error("config write did not reach the converter bits");

    io_level_a: assert property (
        hit(reg_req, ADDR_IO_LEVEL) && !warm_reset
        |=> rail_ctrl.io_level_high == $past(reg_req.wdata[0]))
        else $error("io level select did not follow the write");

    sleep_remap_a: assert property (
        power_req == REQ_SLEEP
        |=> rail_ctrl.core_target_state == $past(state_reg.core_remap[3:0]))
        else $error("sleep request not remapped");

    status_read_a: assert property (
        reg_req.read && reg_req.addr == ADDR_CORE_MODE
        |=> reg_rdata[BUSY_BIT] == $past(state_reg.busy)
            && reg_rdata[REACHED_BIT] == $past(state_reg.reached))
        else $error("mode register status bits wrong");

    floor_store_a: assert property (
        hit(reg_req, ADDR_CORE_FLOOR)
        |=> state_reg.core_floor == ($past(reg_req.wdata) & MASK_LEVEL))
        else $error("floor write stored wrong value");

    osc_store_a: assert property (
        hit(reg_req, ADDR_CORE_OSC)
        |=> state_reg.core_osc == ($past(reg_req.wdata) & MASK_OSC))
        else $error("osc write stored wrong value");

    warm_cover_c: cover property (warm_reset && state_reg.core_grp[WARM_BIT]);
    vscale_cover_c: cover property (vscale_enable ##1 reg_req.read
                                    && reg_req.addr == ADDR_CORE_LEVEL);
    sleep_cover_c: cover property (power_req == REQ_SLEEP && state_reg.core_mode[FLOOR_BIT]);
    off_cover_c: cover property (power_req == REQ_OFF);
    busy_cover_c: cover property (state_reg.busy && state_reg.reached);

endmodule // regulator_control_regs

// ==== regulator_ctrl_pkg.sv ====
// Constants, register map and carrier types of the regulator control bank.
// Assumes one 10 MHz clock domain shared with the control-interface engine.
package regulator_ctrl_pkg;

    // ****************************************************************
    // Register offsets on the control interface
    // ****************************************************************
    localparam logic [7:0] ADDR_IO_CFG     = 8'ha9;
    localparam logic [7:0] ADDR_IO_MISC    = 8'haa;
    localparam logic [7:0] ADDR_IO_OSC     = 8'had;
    localparam logic [7:0] ADDR_IO_LEVEL   = 8'haf;
    localparam logic [7:0] ADDR_CORE_GRP   = 8'hb0;
    localparam logic [7:0] ADDR_CORE_KIND  = 8'hb1;
    localparam logic [7:0] ADDR_CORE_REMAP = 8'hb2;
    localparam logic [7:0] ADDR_CORE_CFG   = 8'hb3;
    localparam logic [7:0] ADDR_CORE_MISC  = 8'hb4;
    localparam logic [7:0] ADDR_CORE_OSC   = 8'hb7;
    localparam logic [7:0] ADDR_CORE_LEVEL = 8'hb9;
    localparam logic [7:0] ADDR_CORE_MODE  = 8'hba;
    localparam logic [7:0] ADDR_CORE_FLOOR = 8'hbb;

    // ****************************************************************
    // Writable-bit masks; bits outside a mask are read-only
    // ****************************************************************
    localparam logic [7:0] MASK_CFG   = 8'h03;
    localparam logic [7:0] MASK_MISC  = 8'h1f;
    localparam logic [7:0] MASK_OSC   = 8'h5f;
    localparam logic [7:0] MASK_IOLVL = 8'h01;
    localparam logic [7:0] MASK_GRP   = 8'hf0;
    localparam logic [7:0] MASK_KIND  = 8'h1f;
    localparam logic [7:0] MASK_REMAP = 8'hff;
    localparam logic [7:0] MASK_LEVEL = 8'h7f;
    localparam logic [7:0] MASK_MODE  = 8'h07;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_GRP    = 8'h20;
    localparam logic [7:0] RST_KIND   = 8'h04;
    localparam logic [7:0] RST_REMAP  = 8'h08;
    localparam logic [7:0] RST_LEVEL  = 8'h30;
    localparam logic [2:0] GRP_ALL    = 3'h7;
    localparam logic [2:0] SYNC_CLEAR = 3'h0;

    // Resource state code for an unremapped active request (arbitrary)
    localparam logic [3:0] STATE_ACTIVE = 4'he;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int GRP_LSB      = 5;
    localparam int WARM_BIT     = 4;
    localparam int FLOOR_BIT    = 2;
    localparam int READBACK_BIT = 1;
    localparam int BUSY_BIT     = 5;
    localparam int REACHED_BIT  = 3;
    localparam int OFF_LSB      = 4;

    // System power request toward the rail
    typedef enum logic [1:0] {
        REQ_ACTIVE,
        REQ_SLEEP,
        REQ_OFF
    } power_req_type;

    // Register access from the control-interface engine
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // Stored bank plus synchronisers and registered outputs
    typedef struct packed {
        logic [7:0] io_cfg;
        logic [7:0] io_misc;
        logic [7:0] io_osc;
        logic [7:0] io_level;
        logic [7:0] core_grp;
        logic [7:0] core_kind;
        logic [7:0] core_remap;
        logic [7:0] core_cfg;
        logic [7:0] core_misc;
        logic [7:0] core_osc;
        logic [7:0] core_level;
        logic [7:0] core_mode;
        logic [7:0] core_floor;
        logic [6:0] active_level;
        logic [6:0] sleep_level;
        logic [3:0] target_state;
        logic [2:0] busy_sync;
        logic [2:0] reached_sync;
        logic       busy;
        logic       reached;
        logic [7:0] rdata;
    } bank_state_type;

    // Control fields handed to the converters
    typedef struct packed {
        logic [1:0] io_cfg;
        logic [4:0] io_misc;
        logic [4:0] io_osc;
        logic       io_level_high;
        logic [2:0] core_group;
        logic [4:0] core_kind;
        logic [1:0] core_cfg;
        logic [4:0] core_misc;
        logic [4:0] core_osc;
        logic [6:0] core_active_level;
        logic [6:0] core_sleep_level;
        logic [3:0] core_target_state;
    } rail_ctrl_type;

endpackage

// ==== tb_top.sv ====
// Self-checking bench for the regulator control bank.
// Assumes the strobe port of the bank and a 10 MHz clock.
`timescale 1ns/1ps
module tb_top
    import regulator_ctrl_pkg::*;
;
    // ****************************************************************
    // Stimulus, instances and shared tasks
    // ****************************************************************
    logic          clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          warm_reset = 1'b0;
    logic          vscale_enable = 1'b0;
    logic          busy_cmd = 1'b0;
    logic          floor_cmd = 1'b0;
    logic [3:0]    core_resource_state = 4'h5;
    logic [6:0]    vscale_level = 7'h55;
    reg_req_type   reg_req = '0;
    power_req_type power_req = REQ_ACTIVE;
    logic [7:0]    reg_rdata;
    rail_ctrl_type rail_ctrl;
    logic          transition_in_progress;
    logic          floor_reached;
    int            bad_count = 0;
    int            comparisons = 0;
    // Map walk: offset, reset read, writable mask; last entry is unmapped
    localparam logic [7:0] ADDRS [14] = '{ADDR_IO_CFG, ADDR_IO_MISC, ADDR_IO_OSC,
        ADDR_IO_LEVEL, ADDR_CORE_GRP, ADDR_CORE_KIND, ADDR_CORE_REMAP, ADDR_CORE_CFG,
        ADDR_CORE_MISC, ADDR_CORE_OSC, ADDR_CORE_LEVEL, ADDR_CORE_MODE, ADDR_CORE_FLOOR,
        8'ha0};
    localparam logic [7:0] RSTS [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h25, 8'h04,
        8'h08, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MASKS [14] = '{8'h03, 8'h1f, 8'h5f, 8'h01, 8'hf0, 8'h1f,
        8'hff, 8'h03, 8'h1f, 8'h5f, 8'h7f, 8'h07, 8'h7f, 8'h00};

    always #50 clk = ~clk;

    regulator_control_regs dut_u (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .warm_reset(warm_reset), .power_req(power_req),
        .core_resource_state(core_resource_state), .vscale_enable(vscale_enable),
        .vscale_level(vscale_level), .transition_in_progress(transition_in_progress),
        .floor_reached(floor_reached), .rail_ctrl(rail_ctrl));

    converter_status_model status_u (.clk(clk), .busy_cmd(busy_cmd),
        .floor_cmd(floor_cmd), .transition_in_progress(transition_in_progress),
        .floor_reached(floor_reached));

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        comparisons++;
        if (seen !== expected) begin
            bad_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, expected);
        end
    endtask

    // One-cycle strobes; an idle negedge between calls avoids double drives
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_req = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
        @(negedge clk);
        reg_req.write = 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [7:0] expected);
        @(negedge clk);
        reg_req = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk);
        reg_req.read = 1'b0;
        check(reg_rdata, expected);
    endtask

    task automatic warm_pulse;
        @(negedge clk);
        warm_reset = 1'b1;
        @(negedge clk);
        warm_reset = 1'b0;
    endtask

    task automatic finish_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 14; i++) rd_check(ADDRS[i], RSTS[i]);
        check({4'h0, rail_ctrl.core_target_state}, {4'h0, STATE_ACTIVE});
        check({5'h0, rail_ctrl.core_group}, 8'h01);
        check({3'h0, rail_ctrl.core_kind}, 8'h04);
        for (int i = 0; i < 14; i++) wr(ADDRS[i], 8'hff);
        for (int i = 0; i < 14; i++) rd_check(ADDRS[i], MASKS[i] | ((i == 4) ? 8'h05 : 8'h00));
        check({6'h0, rail_ctrl.io_cfg}, 8'h03);
        check({6'h0, rail_ctrl.core_cfg}, 8'h03);
        check({3'h0, rail_ctrl.io_osc}, 8'h1f);
        check({3'h0, rail_ctrl.core_kind}, 8'h1f);
        check({5'h0, rail_ctrl.core_group}, 8'h07);
        // Readback select with external scaling in control
        vscale_enable = 1'b1;
        wr(ADDR_CORE_LEVEL, 8'h40);
        rd_check(ADDR_CORE_LEVEL, 8'h40);
        wr(ADDR_CORE_MODE, 8'h00);
        rd_check(ADDR_CORE_LEVEL, 8'h55);
        check({1'b0, rail_ctrl.core_active_level}, 8'h55);
        vscale_enable = 1'b0;
        repeat (2) @(negedge clk);
        check({1'b0, rail_ctrl.core_active_level}, 8'h40);
        // State remap and sleep floor
        wr(ADDR_CORE_REMAP, 8'h3c);
        wr(ADDR_CORE_FLOOR, 8'h12);
        wr(ADDR_CORE_MODE, 8'h04);
        power_req = REQ_OFF;
        repeat (2) @(negedge clk);
        check({4'h0, rail_ctrl.core_target_state}, 8'h03);
        power_req = REQ_SLEEP;
        repeat (2) @(negedge clk);
        check({4'h0, rail_ctrl.core_target_state}, 8'h0c);
        check({1'b0, rail_ctrl.core_sleep_level}, 8'h12);
        wr(ADDR_CORE_MODE, 8'h00);
        repeat (2) @(negedge clk);
        check({1'b0, rail_ctrl.core_sleep_level}, 8'h40);
        // Status lines through the synchronisers
        busy_cmd = 1'b1;
        floor_cmd = 1'b1;
        repeat (6) @(negedge clk);
        rd_check(ADDR_CORE_MODE, 8'h28);
        busy_cmd = 1'b0;
        floor_cmd = 1'b0;
        repeat (6) @(negedge clk);
        rd_check(ADDR_CORE_MODE, 8'h00);
        // Software-inverted drive and overlap codes stored raw
        wr(ADDR_IO_MISC, 8'h07);
        wr(ADDR_CORE_MISC, 8'h03);
        wr(ADDR_CORE_OSC, 8'h18);
        repeat (2) @(negedge clk);
        check({3'h0, rail_ctrl.io_misc}, 8'h07);
        check({3'h0, rail_ctrl.core_misc}, 8'h03);
        check({3'h0, rail_ctrl.core_osc}, 8'h18);
        // Warm reset with and without the group policy bit
        wr(ADDR_CORE_GRP, 8'h10);
        wr(ADDR_IO_LEVEL, 8'h01);
        wr(ADDR_CORE_MODE, 8'h02);
        repeat (2) @(negedge clk);
        check({7'h0, rail_ctrl.io_level_high}, 8'h01);
        warm_pulse();
        rd_check(ADDR_CORE_GRP, 8'hf5);
        rd_check(ADDR_IO_LEVEL, 8'h00);
        rd_check(ADDR_CORE_LEVEL, 8'h30);
        wr(ADDR_CORE_GRP, 8'h4f);
        warm_pulse();
        rd_check(ADDR_CORE_GRP, 8'h45);
        core_resource_state = 4'ha;
        rd_check(ADDR_CORE_GRP, 8'h4a);
        // Second reset in mid-run
        @(negedge clk);
        reset_n = 1'b0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        rd_check(ADDR_CORE_GRP, 8'h2a);
        rd_check(ADDR_CORE_LEVEL, 8'h30);
        check({4'h0, rail_ctrl.core_target_state}, 8'h08);
        check({5'h0, rail_ctrl.core_group}, 8'h01);
        finish_test();
    end
endmodule // tb_top
